// ==== ext_bus_cycle_phase_sequencer.sv ====
// External bus cycle phase sequencer with AXI4-Lite register access
// Notes on behaviour
// - Each bus cycle runs address setup, command delay, data setup, access, hold in order.
// - Phase lengths come from a software timing word per chip select.
// - Address setup lasts 1 or 2 units, plus 0 to 3 on a window change.
// - Command delay lasts 0 to 3 units.
// - Write data setup or tristate lasts 0 or 1 unit.
// - Access lasts 1 to 32 units before any ready extension.
// - Hold of address and write data lasts 0 to 3 units.
// - Optionally the external module ends the access phase through ready.
// - Reference clock output is the system clock when selected, same period.
// - Ready sampled inactive inserts a waitstate; sampled active ends the access phase.
// - Ready polarity selectable; asynchronous mode adds one synchroniser stage.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "ext_bus_defines.svh"
module ext_bus_cycle_phase_sequencer (
  input wire logic aclk, // System clock, 25 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [23:0] bus_addr, // External address
  output logic bus_ale, // Address latch enable, high in address setup
  output logic [3:0] bus_cs_n, // Chip selects, active low
  output logic bus_rd_n, // Read command, active low
  output logic bus_wr_n, // Write command, active low
  output logic [15:0] bus_data_o, // Write data out
  output logic bus_data_oe, // Data bus drive enable
  input wire logic [15:0] bus_data_i, // Read data in
  input wire logic bus_ready, // Ready handshake pin
  output logic ref_clock_out // Reference clock output
);
  ext_bus_pkg::seq_state_t s_reg;
  ext_bus_pkg::seq_state_t s_next;
  phase_tick_if tk ();

  phase_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk)
  );

  assign tk.scale = s_reg.clkcfg[`CK_SCALE_HI:`CK_SCALE_LO];
  assign tk.run = (s_reg.phase != ext_bus_pkg::PH_IDLE);

  // Count minus one for the unit length of a phase
  function automatic logic [4:0] phase_cnt(ext_bus_pkg::phase_t p, logic [31:0] c, logic wchg);
    logic [4:0] n;
    n = 5'h00;
    case (p)
      ext_bus_pkg::PH_ADDR: n = 5'(c[`TC_AB]) + (wchg ? 5'(c[`TC_EXT_HI:`TC_EXT_LO]) : 5'h00);
      ext_bus_pkg::PH_CMD: n = 5'(c[`TC_CMD_HI:`TC_CMD_LO]) - 5'h01;
      ext_bus_pkg::PH_DSET: n = 5'h00;
      ext_bus_pkg::PH_ACC: n = c[`TC_ACC_HI:`TC_ACC_LO];
      ext_bus_pkg::PH_HOLD: n = 5'(c[`TC_HOLD_HI:`TC_HOLD_LO]) - 5'h01;
      default: n = 5'h00;
    endcase
    return n;
  endfunction

  // Phase after command delay, skipping empty ones
  function automatic ext_bus_pkg::phase_t after_cmd(logic [31:0] c);
    return c[`TC_DS] ? ext_bus_pkg::PH_DSET : ext_bus_pkg::PH_ACC;
  endfunction

  function automatic ext_bus_pkg::phase_t after_acc(logic [31:0] c);
    return (c[`TC_HOLD_HI:`TC_HOLD_LO] != 2'h0) ? ext_bus_pkg::PH_HOLD : ext_bus_pkg::PH_IDLE;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic busy;
  logic rdy_sel;
  logic rdy_act;
  logic cmd_on;
  assign busy = (s_reg.phase != ext_bus_pkg::PH_IDLE);
  assign rdy_sel = s_reg.cur_cfg[`TC_RDY_ASYNC] ? s_reg.rdy_s3 : s_reg.rdy_s2;
  assign rdy_act = s_reg.cur_cfg[`TC_RDY_POL] ? rdy_sel : ~rdy_sel;
  assign cmd_on = (s_reg.phase == ext_bus_pkg::PH_ACC) || (s_reg.phase == ext_bus_pkg::PH_RDY);

  always_comb begin
    logic [31:0] cfg;
    logic wchg;
    logic do_wr;
    logic start;
    logic set_done;
    logic ends;
    ext_bus_pkg::phase_t np;
    cfg = s_reg.cur_cfg;
    wchg = 1'b0;
    do_wr = 1'b0;
    start = 1'b0;
    set_done = 1'b0;
    ends = 1'b0;
    np = s_reg.phase;
    s_next = s_reg;

    // Pin synchroniser; third stage serves the asynchronous ready mode
    s_next.rdy_s1 = bus_ready;
    s_next.rdy_s2 = s_reg.rdy_s1;
    s_next.rdy_s3 = s_reg.rdy_s2;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      do_wr = 1'b1;
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `RESP_OKAY;
      case (s_reg.awaddr)
        `OFF_CTRL: begin
          s_next.ctrl = merge(s_reg.ctrl, s_reg.wdata, s_reg.wstrb) & 32'h0000_000E;
          start = s_reg.wstrb[0] && s_reg.wdata[`CTRL_START] && !busy;
        end
        `OFF_ADDR: s_next.addr = 24'(merge({8'h00, s_reg.addr}, s_reg.wdata, s_reg.wstrb));
        `OFF_WDATA: s_next.wdat = 16'(merge({16'h0000, s_reg.wdat}, s_reg.wdata, s_reg.wstrb));
        `OFF_STATUS: ;
        `OFF_CLKCFG: s_next.clkcfg = merge(s_reg.clkcfg, s_reg.wdata, s_reg.wstrb) & 32'h0000_FF01;
        `OFF_RDATA: ;
        default: begin
          if (s_reg.awaddr >= `OFF_TCFG0 && s_reg.awaddr <= `OFF_TCFG3
              && s_reg.awaddr[1:0] == 2'h0) begin
            s_next.tcfg[s_reg.awaddr[3:2]] =
              merge(s_reg.tcfg[s_reg.awaddr[3:2]], s_reg.wdata, s_reg.wstrb);
          end else begin
            s_next.bresp = `RESP_SLVERR;
          end
        end
      endcase
    end

    // Read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `OFF_CTRL: s_next.rdata = s_reg.ctrl;
        `OFF_ADDR: s_next.rdata = {8'h00, s_reg.addr};
        `OFF_WDATA: s_next.rdata = {16'h0000, s_reg.wdat};
        `OFF_RDATA: s_next.rdata = {16'h0000, s_reg.rddat};
        `OFF_STATUS: s_next.rdata = {27'h0, s_reg.done, s_reg.phase, busy};
        `OFF_CLKCFG: s_next.rdata = s_reg.clkcfg;
        default: begin
          if (s_axi_araddr >= `OFF_TCFG0 && s_axi_araddr <= `OFF_TCFG3
              && s_axi_araddr[1:0] == 2'h0) begin
            s_next.rdata = s_reg.tcfg[s_axi_araddr[3:2]];
          end else begin
            s_next.rresp = `RESP_SLVERR;
          end
        end
      endcase
    end

    // Phase sequencer
    if (start) begin
      cfg = s_reg.tcfg[s_reg.wdata[`CTRL_CS_HI:`CTRL_CS_LO]];
      wchg = (s_reg.last_cs != {1'b0, s_reg.wdata[`CTRL_CS_HI:`CTRL_CS_LO]});
      s_next.cur_cfg = cfg;
      s_next.last_cs = {1'b0, s_reg.wdata[`CTRL_CS_HI:`CTRL_CS_LO]};
      s_next.phase = ext_bus_pkg::PH_ADDR;
      s_next.cnt = phase_cnt(ext_bus_pkg::PH_ADDR, cfg, wchg);
    end else if (busy && tk.tick) begin
      if (s_reg.cnt != 5'h00) begin
        s_next.cnt = s_reg.cnt - 5'h01;
      end else begin
        case (s_reg.phase)
          ext_bus_pkg::PH_ADDR:
            np = (cfg[`TC_CMD_HI:`TC_CMD_LO] != 2'h0) ? ext_bus_pkg::PH_CMD : after_cmd(cfg);
          ext_bus_pkg::PH_CMD: np = after_cmd(cfg);
          ext_bus_pkg::PH_DSET: np = ext_bus_pkg::PH_ACC;
          ext_bus_pkg::PH_ACC, ext_bus_pkg::PH_RDY: begin
            if (cfg[`TC_RDY_EN] && !rdy_act) begin
              np = ext_bus_pkg::PH_RDY;
            end else begin
              np = after_acc(cfg);
              ends = 1'b1;
            end
          end
          ext_bus_pkg::PH_HOLD: np = ext_bus_pkg::PH_IDLE;
          default: np = ext_bus_pkg::PH_IDLE;
        endcase
        if (ends && !s_reg.ctrl[`CTRL_WRITE]) begin
          s_next.rddat = bus_data_i;
        end
        set_done = (np == ext_bus_pkg::PH_IDLE);
        s_next.phase = np;
        s_next.cnt = phase_cnt(np, cfg, 1'b0);
      end
    end

    // Done flag: a completion in the clearing cycle wins
    s_next.done = set_done || (s_reg.done && !(do_wr && s_reg.awaddr == `OFF_STATUS
      && s_reg.wstrb[0] && s_reg.wdata[`ST_DONE]));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.last_cs <= `NO_LAST_CS;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  assign bus_addr = s_reg.addr;
  assign bus_data_o = s_reg.wdat;
  assign bus_ale = (s_reg.phase == ext_bus_pkg::PH_ADDR);
  assign bus_rd_n = !(cmd_on && !s_reg.ctrl[`CTRL_WRITE]);
  assign bus_wr_n = !(cmd_on && s_reg.ctrl[`CTRL_WRITE]);
  assign bus_data_oe = s_reg.ctrl[`CTRL_WRITE] && (s_reg.phase == ext_bus_pkg::PH_DSET
    || cmd_on || s_reg.phase == ext_bus_pkg::PH_HOLD);

  for (genvar i = 0; i < `NUM_CS; i++) begin : g_cs
    assign bus_cs_n[i] = !(busy && s_reg.last_cs == 3'(i));
  end

  // System clock driven straight out when selected, so its period is one system clock
  assign ref_clock_out = aclk & s_reg.clkcfg[`CK_SEL];
endmodule

// ==== ext_bus_cycle_phase_sequencer_tb.sv ====
// Self-checking bench of the external bus cycle phase sequencer
`timescale 1ns/100ps
`include "ext_bus_defines.svh"
module ext_bus_cycle_phase_sequencer_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, scale = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, bus_cs_n;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rdy_pol = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] bus_addr;
  logic bus_ale, bus_rd_n, bus_wr_n, bus_data_oe, bus_ready, ref_clock_out;
  logic [15:0] bus_data_o, bus_data_i;
  logic [4:0] rdy_delay = 5'h1F;
  logic [11:0] a = 12'h0, g = 12'h0, c = 12'h0, h = 12'h0;
  logic [2:0] last_cs = `NO_LAST_CS;
  logic [33:0] axi_q[$];
  logic [59:0] bus_q[$];
  int mismatches = 0, compares = 0, cycles = 0, ncyc = 0, edges = 0;
  always #20 aclk = ~aclk;
  ext_bus_cycle_phase_sequencer ext_bus_cycle_phase_sequencer_i (.*);
  ext_mem_model ext_mem_model_i (.aclk, .bus_addr, .bus_rd_n, .bus_wr_n, .bus_data_o,
    .rdy_delay, .rdy_pol, .bus_data_i, .bus_ready);
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      finish_test();
    end
  end
  always @(posedge ref_clock_out) edges++;
  // Result watcher: AXI answers and the phase lengths of every bus cycle
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, axi_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, axi_q.pop_front());
    if (bus_cs_n !== 4'hF) begin
      if (bus_ale) a <= a + 12'h1;
      else if (!bus_rd_n || !bus_wr_n) c <= c + 12'h1;
      else if (c == 12'h0) g <= g + 12'h1;
      else h <= h + 12'h1;
    end else if (a != 12'h0) begin
      check({a, g, h}, bus_q[0][59:24]);
      check(c >= bus_q[0][23:12] && c <= bus_q[0][23:12] + bus_q[0][11:0], 1'b1);
      void'(bus_q.pop_front());
      {a, g, c, h} <= 48'h0;
      ncyc <= ncyc + 1;
    end
  end
  task automatic wr(input [7:0] ad, input [31:0] d, input [1:0] rs);
    axi_q.push_back({rs, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] ad, input [31:0] d, input [1:0] rs);
    axi_q.push_back({rs, d});
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [31:0] tc(input logic [1:0] ab, ext, cmd, input logic ds,
    input logic [5:0] acc, input logic [1:0] hold, input logic [2:0] rdy);
    return {15'h0, rdy, hold, 5'(acc - 6'h1), ds, cmd, ext, 1'b0, 1'(ab - 2'h1)};
  endfunction
  function automatic logic [31:0] rnd_cfg();
    return tc($urandom_range(2, 1), $urandom_range(3, 0), $urandom_range(3, 0),
      $urandom_range(1, 0), $urandom_range(32, 1), $urandom_range(3, 0), 3'h0);
  endfunction
  // One bus cycle; lo of zero means the programmed access length
  task automatic cyc(input [1:0] cs, input wr_cyc, input [31:0] cfg, input [11:0] lo, sl);
    logic [11:0] u;
    int n0;
    u = 12'(scale) + 12'h1;
    wr(`OFF_TCFG0 + {4'h0, cs, 2'h0}, cfg, `RESP_OKAY);
    if (lo == 12'h0) lo = (12'(cfg[11:7]) + 12'h1) * u;
    bus_q.push_back({(12'(cfg[0]) + 12'h1 + (({1'b0, cs} != last_cs) ? 12'(cfg[3:2]) : 12'h0)) * u,
      (12'(cfg[5:4]) + 12'(cfg[6])) * u, 12'(cfg[13:12]) * u, lo, sl});
    last_cs = {1'b0, cs};
    n0 = ncyc;
    wr(`OFF_CTRL, {28'h0, cs, wr_cyc, 1'b1}, `RESP_OKAY);
    while (ncyc == n0) @(posedge aclk);
  endtask
  initial begin
    logic [31:0] r;
    void'($urandom(32'h5EBCDDC0));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_TCFG0, `TCFG_RESET, `RESP_OKAY);
    rd(`OFF_STATUS, 32'h0, `RESP_OKAY);
    rd(`OFF_CLKCFG, 32'h0, `RESP_OKAY);
    rd(8'h18, 32'h0, `RESP_SLVERR);
    wr(8'h18, 32'hFFFF_FFFF, `RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      r = $urandom() & 32'h0001_FFFF;
      wr(`OFF_TCFG0 + 8'(4 * i), r, `RESP_OKAY);
      rd(`OFF_TCFG0 + 8'(4 * i), r, `RESP_OKAY);
    end
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      scale = (i < 5) ? 8'h00 : 8'h02;
      wr(`OFF_CLKCFG, {16'h0, scale, 8'h00}, `RESP_OKAY);
      r = {16'h0, 16'($urandom())};
      wr(`OFF_ADDR, $urandom() & 32'h00FF_FFFF, `RESP_OKAY);
      wr(`OFF_WDATA, r, `RESP_OKAY);
      cyc(2'(i), 1'b1, i == 0 ? tc(1, 0, 0, 0, 1, 0, 0) : i == 1 ? tc(2, 3, 3, 1, 32, 3, 0) :
        rnd_cfg(), 12'h0, 12'h0);
      cyc(2'(i), 1'b0, rnd_cfg(), 12'h0, 12'h0);
      rd(`OFF_RDATA, r, `RESP_OKAY);
    end
    $display("test phases done");
    scale = 8'h00;
    wr(`OFF_CLKCFG, 32'h0, `RESP_OKAY);
    rdy_delay <= 5'h4;
    cyc(2'h0, 1'b0, tc(1, 0, 0, 0, 1, 0, 3'b011), 12'h5, 12'h5);
    rdy_pol <= 1'b0;
    cyc(2'h0, 1'b1, tc(1, 0, 0, 0, 1, 0, 3'b001), 12'h5, 12'h5);
    rdy_pol <= 1'b1;
    rdy_delay <= 5'h0;
    cyc(2'h0, 1'b0, tc(1, 0, 0, 0, 1, 0, 3'b111), 12'h2, 12'h5);
    rd(`OFF_STATUS, 32'h10, `RESP_OKAY);
    wr(`OFF_STATUS, 32'h10, `RESP_OKAY);
    rd(`OFF_STATUS, 32'h0, `RESP_OKAY);
    $display("test ready done");
    for (int s = 0; s < 2; s++) begin
      wr(`OFF_CLKCFG, 32'(s), `RESP_OKAY);
      @(negedge aclk);
      r = edges;
      repeat (10) @(negedge aclk);
      check(edges - r, 10 * s);
    end
    $display("test clock done");
    repeat (5) @(posedge aclk);
    finish_test();
  end
endmodule

// ==== ext_bus_defines.svh ====
// Register offsets, field positions, reset values and sizes of the external bus sequencer
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH

`define NUM_CS 4
`define ADDR_W 24
`define DATA_W 16
`define SCALE_W 8
`define CNT_W 5

`define OFF_CTRL 8'h00
`define OFF_ADDR 8'h04
`define OFF_WDATA 8'h08
`define OFF_RDATA 8'h0C
`define OFF_STATUS 8'h10
`define OFF_CLKCFG 8'h14
`define OFF_TCFG0 8'h20
`define OFF_TCFG3 8'h2C

`define CTRL_START 0
`define CTRL_WRITE 1
`define CTRL_CS_LO 2
`define CTRL_CS_HI 3

`define ST_BUSY 0
`define ST_PH_LO 1
`define ST_PH_HI 3
`define ST_DONE 4

`define CK_SEL 0
`define CK_SCALE_LO 8
`define CK_SCALE_HI 15

`define TC_AB 0
`define TC_EXT_LO 2
`define TC_EXT_HI 3
`define TC_CMD_LO 4
`define TC_CMD_HI 5
`define TC_DS 6
`define TC_ACC_LO 7
`define TC_ACC_HI 11
`define TC_HOLD_LO 12
`define TC_HOLD_HI 13
`define TC_RDY_EN 14
`define TC_RDY_POL 15
`define TC_RDY_ASYNC 16

`define TCFG_RESET 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define NO_LAST_CS 3'h4

`endif

// ==== ext_bus_pkg.sv ====
// Types of the external bus sequencer
package ext_bus_pkg;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_CMD = 3'b010,
    PH_DSET = 3'b011,
    PH_ACC = 3'b100,
    PH_RDY = 3'b101,
    PH_HOLD = 3'b110
  } phase_t;

  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [23:0] addr;
    logic [15:0] wdat;
    logic [15:0] rddat;
    logic done;
    logic [31:0] clkcfg;
    logic [3:0][31:0] tcfg;
    logic [31:0] cur_cfg;
    phase_t phase;
    logic [4:0] cnt;
    logic [2:0] last_cs;
    logic rdy_s1;
    logic rdy_s2;
    logic rdy_s3;
  } seq_state_t;

  typedef struct packed {
    logic [7:0] cnt;
  } tick_state_t;

endpackage

// ==== ext_bus_seq_asserts.sv ====
// Assertions on the external bus pins of the phase sequencer
`timescale 1ns/100ps
module ext_bus_seq_asserts (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic [23:0] bus_addr, // Address
  input wire logic bus_ale, // Address phase
  input wire logic [3:0] bus_cs_n, // Selects
  input wire logic bus_rd_n, // Read
  input wire logic bus_wr_n, // Write
  input wire logic bus_data_oe // Drive
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [10:0] ale_cnt;
  logic [10:0] gap_cnt;
  logic cmd;
  assign cmd = !bus_rd_n || !bus_wr_n;
  // Longest legal runs: 5 and 4 units at a unit of 256 clocks
  always_ff @(posedge aclk) begin
    ale_cnt <= (aresetn && bus_ale) ? ale_cnt + 11'h1 : 11'h0;
    gap_cnt <= (aresetn && bus_cs_n != 4'hF && !bus_ale && !cmd) ? gap_cnt + 11'h1 : 11'h0;
  end
  sequence s_begin;
    $past(bus_cs_n) == 4'hF && bus_cs_n != 4'hF;
  endsequence
  sequence s_cmd_end;
    $rose(bus_rd_n) || $rose(bus_wr_n);
  endsequence
  sequence s_idle;
    bus_cs_n == 4'hF && !bus_data_oe;
  endsequence
  property p_one_cmd;
    !(!bus_rd_n && !bus_wr_n) && !(bus_ale && cmd);
  endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("phases overlap");
  property p_ale_first;
    s_begin |-> bus_ale;
  endproperty
  a_ale_first: assert property (p_ale_first) else $error("no address phase");
  property p_cmd_cs;
    cmd |-> $onehot(~bus_cs_n);
  endproperty
  a_cmd_cs: assert property (p_cmd_cs) else $error("select not single");
  property p_ale_len;
    ale_cnt <= 11'h500;
  endproperty
  a_ale_len: assert property (p_ale_len) else $error("address phase too long");
  property p_gap_len;
    gap_cnt <= 11'h400;
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("command delay too long");
  property p_oe;
    cmd |-> bus_data_oe == !bus_wr_n;
  endproperty
  a_oe: assert property (p_oe) else $error("data drive wrong");
  property p_hold_end;
    s_cmd_end |-> ##[0:768] s_idle;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("hold too long");
  property p_stable;
    (bus_cs_n != 4'hF && $past(bus_cs_n) != 4'hF) |-> $stable({bus_addr, bus_cs_n});
  endproperty
  a_stable: assert property (p_stable) else $error("address moved in cycle");
endmodule

bind ext_bus_cycle_phase_sequencer ext_bus_seq_asserts ext_bus_seq_asserts_i (
  .aclk(aclk), .aresetn(aresetn), .bus_addr(bus_addr), .bus_ale(bus_ale),
  .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_data_oe(bus_data_oe)
);

// ==== ext_mem_model.sv ====
// Behavioural external memory with a ready handshake
`timescale 1ns/100ps
module ext_mem_model (
  input wire logic aclk, // Clock
  input wire logic [23:0] bus_addr, // Address
  input wire logic bus_rd_n, // Read
  input wire logic bus_wr_n, // Write
  input wire logic [15:0] bus_data_o, // Write data
  input wire logic [4:0] rdy_delay, // Clocks to ready
  input wire logic rdy_pol, // Active level
  output logic [15:0] bus_data_i, // Read data
  output logic bus_ready // Ready pin
);
  logic [15:0] mem [16];
  logic [15:0] churn = 16'h0;
  logic [4:0] wait_cnt = 5'h0;
  always @(posedge aclk) begin
    churn <= churn + 16'h3B1D;
    if (!bus_wr_n) mem[bus_addr[3:0]] <= bus_data_o;
    if (bus_rd_n && bus_wr_n) wait_cnt <= 5'h0;
    else if (wait_cnt != 5'h1F) wait_cnt <= wait_cnt + 5'h1;
  end
  // Undriven bus shows a moving value
  assign bus_data_i = !bus_rd_n ? mem[bus_addr[3:0]] : churn;
  // Ready drops with the command, so the next cycle starts unready
  assign bus_ready = (!(bus_rd_n && bus_wr_n) && wait_cnt >= rdy_delay) ? rdy_pol : !rdy_pol;
endmodule

// ==== phase_tick_gen.sv ====
// Phase time unit generator: one-cycle tick every scale+1 system clocks while running
`timescale 1ns/100ps
module phase_tick_gen (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  phase_tick_if.gen tk // Scale, run and tick
);
  ext_bus_pkg::tick_state_t s_reg;
  ext_bus_pkg::tick_state_t s_next;

  assign tk.tick = tk.run && (s_reg.cnt == tk.scale);

  always_comb begin
    s_next = s_reg;
    if (!tk.run || tk.tick) begin
      s_next.cnt = 8'h00;
    end else begin
      s_next.cnt = s_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// ==== phase_tick_if.sv ====
// Carrier between the sequencer and its phase time unit generator
`timescale 1ns/100ps
interface phase_tick_if;
  logic [7:0] scale;
  logic run;
  logic tick;
  modport gen (input scale, input run, output tick);
  modport user (output scale, output run, input tick);
endinterface
